// ==== common/bbf_pkg.sv ====
// Types shared by the block boundary filter
package bbf_pkg;
  // Mode bits, high bit first
  typedef struct packed {
    logic rect_slice;
    logic isd_mode;
    logic slice_mode;
    logic rru_mode;
    logic deblock_mode;
  } mode_s;

  // Context of one edge, high bit first
  typedef struct packed {
    logic vertical;
    logic chroma;
    logic intra2;
    logic skip2;
    logic intra1;
    logic skip1;
    logic gob_header_border;
    logic slice_border;
    logic picture_border;
  } edge_s;

  // Four pixels across the edge, A nearest the upper/left side start
  typedef struct packed {
    logic [7:0] d;
    logic [7:0] c;
    logic [7:0] b;
    logic [7:0] a;
  } pix_s;

  // Filter result; outer pixels are unclipped signed values
  typedef struct packed {
    logic [9:0] a1;
    logic [7:0] b1;
    logic [7:0] c1;
    logic [9:0] d1;
  } res_s;

  typedef enum logic [1:0] {
    PIC_IDLE = 2'b01,
    PIC_OPEN = 2'b10
  } pic_state_e;
endpackage

// ==== common/bbf_regs.svh ====
// Register offsets, field positions and reset values of the block boundary filter
// Notes on behaviour
// [R1] Filter edges between adjacent 16x16 blocks, both loops
// [R2] Default filter unless deblocking with reduced-resolution update
// [R3] Whole picture filtered before picture store writes
// [R4] Skip picture, slice and headed group borders; code skips headed group borders only with ISD, slice ones only in slice mode
// [R5] Luminance and both chrominance planes are filtered
// [R6] Default filter only when a block is coded
// [R7] A from upper/left block, B from lower/right
// [R8] A=(3A+B+2)/4, B=(A+3B+2)/4, truncating
// [R9] Edges visited in deblocking filter order
// [R10] Deblock deblock_param_a infinite, ramp becomes linear
// [R11] d1=(A-4B+4C-D)/8; B+d1, C-d1 clipped
// [R12] d2 limited by d1/2; A-d2, D+d2 unclipped
// [R13] No filtering across segments with ISD and RRU
// [R14] No deblocking across segments when ISD active
// [R15] Segments are headed group runs without slices
// [R16] With slices, each slice is one segment
// [R17] Producer: ISD with slices needs rectangular slices
// [R18] Pixel clip 0..255; division truncates toward zero
// [R19] Delta limit bounds to plus/minus second magnitude
`ifndef BBF_REGS_SVH
`define BBF_REGS_SVH

`define BBF_OFS_CTRL 12'h000
`define BBF_OFS_EDGE 12'h004
`define BBF_OFS_PIX 12'h008
`define BBF_OFS_CMD 12'h00C
`define BBF_OFS_RES_AD 12'h010
`define BBF_OFS_RES_BC 12'h014
`define BBF_OFS_STATUS 12'h018

`define BBF_CMD_FILTER 0
`define BBF_CMD_PIC_START 1
`define BBF_CMD_PIC_END 2

`define BBF_ST_DONE 0
`define BBF_ST_APPLIED 1
`define BBF_ST_MASKED 2
`define BBF_ST_PIC_OPEN 3
`define BBF_ST_CFG_ERR 4
`define BBF_ST_COUNT_LSB 16

`define BBF_CTRL_RESET 5'h00
`define BBF_EDGE_RESET 9'h000
`define BBF_PIX_RESET 32'h00000000

`endif

// ==== hw/bbf_filter.sv ====
// Block boundary filter with APB register access
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ns
`include "bbf_regs.svh"
module bbf_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic store_write_allow
);
  import bbf_pkg::*;

  bbf_pkg::mode_s mode_r, mode_nxt;       // Coding modes
  bbf_pkg::edge_s edge_r, edge_nxt;       // Current edge context
  bbf_pkg::pix_s pix_r, pix_nxt;          // Pixels of the current line
  bbf_pkg::res_s res_r, res_nxt;          // Last result
  bbf_pkg::pic_state_e pic_r, pic_nxt;    // Picture framing state
  logic done_r, done_nxt;                 // Result ready, sticky
  logic applied_r, applied_nxt;           // Last edge was changed
  logic masked_r, masked_nxt;             // Last edge was skipped
  logic [15:0] count_r, count_nxt;        // Edges taken in this picture

  logic wr_en;                            // Write access phase
  logic rd_en;                            // Read access phase
  logic mapped;                           // Address hits a register
  logic go;                               // Filter command this cycle
  logic seg_border;                       // Edge lies on a segment border
  logic skip_edge;                        // Edge must be left alone
  logic coded;                            // Either block is coded
  logic use_deblock;                      // Modified deblocking variant
  logic cfg_err;                          // Illegal mode combination seen
  logic signed [11:0] a_s, b_s, c_s, d_s; // Pixels widened to signed
  logic signed [11:0] dd1, half, t, lim, dd2;
  logic [9:0] sum_a, sum_b;               // Default filter sums

  // Saturate to the pixel range
  function automatic logic [7:0] clip8(input logic signed [11:0] v);
    if (v < 12'sh000) begin
      clip8 = 8'h00; // [R18]
    end else if (v > 12'sh0FF) begin
      clip8 = 8'hFF; // [R18]
    end else begin
      clip8 = v[7:0];
    end
  endfunction

  // APB decode; zero wait states so pready is constant high
  always_comb begin
    wr_en = psel & penable & pwrite;
    rd_en = psel & penable & ~pwrite;
    case (paddr)
      `BBF_OFS_CTRL, `BBF_OFS_EDGE, `BBF_OFS_PIX, `BBF_OFS_CMD,
      `BBF_OFS_RES_AD, `BBF_OFS_RES_BC, `BBF_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
    pready = 1'b1;
    pslverr = psel & penable & ~mapped;
    go = wr_en & (paddr == `BBF_OFS_CMD) & pwdata[`BBF_CMD_FILTER];
  end

  // Edge masking and variant choice
  always_comb begin
    // Segment borders follow slices in slice mode, headed groups otherwise
    seg_border = mode_r.slice_mode ? edge_r.slice_border    // [R16]
                                   : edge_r.gob_header_border; // [R15]
    // Border skips; one edge per request between 16x16 blocks
    skip_edge = edge_r.picture_border                         // [R4] [R1]
              | (mode_r.slice_mode & edge_r.slice_border)     // [R4]
              | (mode_r.isd_mode & edge_r.gob_header_border)  // [R4]
              | (mode_r.isd_mode & mode_r.rru_mode & seg_border)   // [R13]
              | (mode_r.isd_mode & mode_r.deblock_mode & seg_border); // [R14]
    coded = ~edge_r.skip1 | edge_r.intra1 | ~edge_r.skip2 | edge_r.intra2; // [R6]
    use_deblock = mode_r.deblock_mode & mode_r.rru_mode; // [R2]
    // Flag a producer that breaks the slice shape constraint
    cfg_err = mode_r.isd_mode & mode_r.slice_mode & ~mode_r.rect_slice; // [R17]
  end

  // Datapath; plane and direction do not change the arithmetic
  always_comb begin
    a_s = $signed({4'h0, pix_r.a}); // [R7] [R5]
    b_s = $signed({4'h0, pix_r.b});
    c_s = $signed({4'h0, pix_r.c});
    d_s = $signed({4'h0, pix_r.d});
    // Default two-tap: sums are never negative, so a shift truncates
    sum_a = 10'(3 * {2'b00, pix_r.a} + {2'b00, pix_r.b} + 10'h002); // [R8]
    sum_b = 10'({2'b00, pix_r.a} + 3 * {2'b00, pix_r.b} + 10'h002); // [R8]
    // Infinite deblock_param_a: the ramp passes its argument through
    dd1 = (a_s - (b_s <<< 2) + (c_s <<< 2) - d_s) / 12'sd8; // [R10] [R11] [R18]
    half = dd1 / 12'sd2;                                  // [R18]
    t = (a_s - d_s) / 12'sd4;                             // [R12]
    lim = (half < 12'sh000) ? -half : half;               // [R19]
    if (t > lim) begin
      dd2 = lim; // [R19]
    end else if (t < -lim) begin
      dd2 = -lim; // [R19]
    end else begin
      dd2 = t;
    end
  end

  // Next register values
  always_comb begin
    mode_nxt = mode_r;
    edge_nxt = edge_r;
    pix_nxt = pix_r;
    res_nxt = res_r;
    pic_nxt = pic_r;
    applied_nxt = applied_r;
    masked_nxt = masked_r;
    count_nxt = count_r;
    done_nxt = done_r;
    // Reading status clears done; a completion in the same cycle wins
    if (rd_en & (paddr == `BBF_OFS_STATUS)) begin
      done_nxt = 1'b0;
    end
    if (wr_en & (paddr == `BBF_OFS_CTRL)) begin
      mode_nxt = pwdata[4:0];
    end
    if (wr_en & (paddr == `BBF_OFS_EDGE)) begin
      edge_nxt = pwdata[8:0];
    end
    if (wr_en & (paddr == `BBF_OFS_PIX)) begin
      pix_nxt = pwdata;
    end
    // Picture framing gates the store from the start command until the end command
    case (pic_r)
      PIC_IDLE: begin
        if (wr_en & (paddr == `BBF_OFS_CMD) & pwdata[`BBF_CMD_PIC_START]) begin
          pic_nxt = PIC_OPEN; // [R3]
          count_nxt = 16'h0000;
        end
      end
      PIC_OPEN: begin
        if (wr_en & (paddr == `BBF_OFS_CMD) & pwdata[`BBF_CMD_PIC_END]) begin
          pic_nxt = PIC_IDLE; // [R3]
        end
      end
      default: pic_nxt = PIC_IDLE;
    endcase
    // Edges are taken strictly in command order
    if (go) begin
      done_nxt = 1'b1;
      count_nxt = count_r + 16'h0001; // [R9]
      res_nxt = {{2'b00, pix_r.a}, pix_r.b, pix_r.c, {2'b00, pix_r.d}};
      applied_nxt = 1'b0;
      masked_nxt = 1'b1;
      if (!skip_edge) begin
        masked_nxt = 1'b0;
        if (use_deblock) begin
          applied_nxt = 1'b1;
          res_nxt.b1 = clip8(b_s + dd1); // [R11]
          res_nxt.c1 = clip8(c_s - dd1); // [R11]
          res_nxt.a1 = 10'(a_s - dd2);   // [R12]
          res_nxt.d1 = 10'(d_s + dd2);   // [R12]
        end else if (coded) begin
          applied_nxt = 1'b1;
          res_nxt.a1 = {2'b00, sum_a[9:2]}; // [R8]
          res_nxt.b1 = sum_b[9:2];          // [R8]
        end
      end
    end
  end

  // Register stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_r <= `BBF_CTRL_RESET;
      edge_r <= `BBF_EDGE_RESET;
      pix_r <= `BBF_PIX_RESET;
      res_r <= 36'h0;
      pic_r <= PIC_IDLE;
      done_r <= 1'b0;
      applied_r <= 1'b0;
      masked_r <= 1'b0;
      count_r <= 16'h0000;
    end else begin
      mode_r <= mode_nxt;
      edge_r <= edge_nxt;
      pix_r <= pix_nxt;
      res_r <= res_nxt;
      pic_r <= pic_nxt;
      done_r <= done_nxt;
      applied_r <= applied_nxt;
      masked_r <= masked_nxt;
      count_r <= count_nxt;
    end
  end

  // Store is held off while a picture is open
  always_comb begin
    store_write_allow = (pic_r == PIC_IDLE); // [R3]
  end

  // Read mux; unmapped and write cycles return zero
  always_comb begin
    prdata = 32'h00000000;
    if (rd_en) begin
      case (paddr)
        `BBF_OFS_CTRL: prdata = {27'h0, mode_r};
        `BBF_OFS_EDGE: prdata = {23'h0, edge_r};
        `BBF_OFS_PIX: prdata = pix_r;
        `BBF_OFS_RES_AD: prdata = {6'h0, res_r.d1, 6'h0, res_r.a1};
        `BBF_OFS_RES_BC: prdata = {16'h0, res_r.c1, res_r.b1};
        `BBF_OFS_STATUS: prdata = {count_r, 11'h0, cfg_err,
                                   (pic_r == PIC_OPEN), masked_r, applied_r, done_r};
        default: prdata = 32'h00000000;
      endcase
    end
  end
endmodule

// ==== verification/bbf_filter_properties.sv ====
// Port checker for the block boundary filter
`timescale 1ns/1ns
module bbf_filter_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic store_write_allow
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc; // Access phase
  logic bad; // Address outside the map
  logic cmd_w; // Write to the command word
  assign acc = psel & penable;
  assign bad = (paddr > 12'h018) | (paddr[1:0] != 2'h0);
  assign cmd_w = acc & pwrite & (paddr == 12'h00C);
  a_ready_const: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc & bad |-> pslverr) else $error("missing slave error");
  a_err_mapped: assert property (acc & !bad |-> !pslverr) else $error("spurious slave error");
  a_rdata_idle: assert property (!(acc & !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read");
  a_rdata_bad: assert property (acc & !pwrite & bad |-> prdata == 32'h0)
    else $error("unmapped read returned data");
  a_cmd_reads_zero: assert property (acc & !pwrite & paddr == 12'h00C |-> prdata == 32'h0)
    else $error("command word read nonzero");
  a_open_blocks: assert property (cmd_w & pwdata[1] & !pwdata[2] & store_write_allow |=>
    !store_write_allow) else $error("store not blocked after picture start");
  a_close_frees: assert property (cmd_w & pwdata[2] & !pwdata[1] & !store_write_allow |=>
    store_write_allow) else $error("store not freed after picture end");
  a_allow_cause: assert property ($changed(store_write_allow) |-> $past(cmd_w))
    else $error("store permission moved without a command");
  c_filter_cmd: cover property (cmd_w & pwdata[0]);
  c_bad_access: cover property (acc & bad);
  c_pic_open: cover property ($fell(store_write_allow));
endmodule

bind bbf_filter bbf_filter_properties chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .store_write_allow(store_write_allow));

// ==== verification/bbf_store_model.sv ====
// Picture store that takes writes only while no picture is being filtered
`timescale 1ns/1ns
module bbf_store_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic store_write_allow,
  input wire logic wr_req,
  output logic [7:0] wr_count
);
  // Writes arriving during an open picture are dropped, not queued
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_count <= 8'h00;
    end else if (wr_req & store_write_allow) begin
      wr_count <= wr_count + 8'h01;
    end
  end
endmodule

// ==== verification/rru_block_boundary_filter_bench.sv ====
// Self-checking bench for the block boundary filter
`timescale 1ns/1ns
module rru_block_boundary_filter_bench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q, ad, bc, st;
  logic pready, pslverr, allow, e, wr_req = 1'b0;
  logic [7:0] wr_count;
  int error_cnt = 0, cmp_count = 0, cyc = 0;
  always #20 pclk = ~pclk;
  bbf_filter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .store_write_allow(allow));
  bbf_store_model store (.pclk(pclk), .presetn(presetn), .store_write_allow(allow),
    .wr_req(wr_req), .wr_count(wr_count));
  task automatic tally_and_finish();
    if (error_cnt == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard, far above the roughly 170 cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer; an idle edge follows so strobes never re-arm in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Sample the answer while it is settled, before the edge that takes it
    @(negedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
      @(negedge pclk);
    end
    q = prdata;
    e = pslverr;
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // Loads mode, edge and pixels, fires the filter and reads results and status
  task automatic run(input logic [31:0] c, input logic [31:0] g, input logic [31:0] p);
    apb(1, 12'h000, c); apb(1, 12'h004, g); apb(1, 12'h008, p); apb(1, 12'h00C, 32'h1);
    apb(0, 12'h010, 32'h0); ad = q;
    apb(0, 12'h014, 32'h0); bc = q;
    apb(0, 12'h018, 32'h0); st = q;
  endtask
  task automatic default_filter();
    run(32'h00, 32'h000, 32'h0000_1E0A); // A=10 B=30, block1 coded
    chk(ad & 32'h3FF, 32'h00F);
    chk(bc & 32'hFF, 32'h019);
    chk(st[1], 1'b1);
    chk(st[0], 1'b1);
    chk(st[31:16], 16'h0001);
  endtask
  task automatic deblock_filter();
    run(32'h03, 32'h028, 32'h5A78_5064); // Uncoded edge still filtered
    chk(ad, 32'h005C_0062);
    chk(bc, 32'h0000_6365);
    run(32'h03, 32'h000, 32'h0000_FAFF); // Negative d1 truncates toward zero
    chk(ad, 32'h002E_00D1);
    chk(bc, 32'h0000_5D9D);
  endtask
  task automatic masked_edges();
    // Segment mode never joins slice mode here, so the shape rule holds
    logic [31:0] tc [4] = '{32'h00, 32'h04, 32'h0A, 32'h00};
    logic [31:0] tg [4] = '{32'h001, 32'h002, 32'h004, 32'h028};
    for (int i = 0; i < 4; i++) begin
      run(tc[i], tg[i], 32'h0000_1E0A);
      chk(ad & 32'h3FF, 32'h00A);
      chk(bc & 32'hFF, 32'h01E);
      chk(st[1], 1'b0);
      chk(st[2], (i < 3));
    end
  endtask
  task automatic picture_and_map();
    wr_req <= 1'b1;
    apb(1, 12'h00C, 32'h2);
    chk(allow, 1'b0);
    chk(wr_count, 8'h02);
    apb(1, 12'h00C, 32'h4);
    chk(allow, 1'b1);
    apb(0, 12'h01C, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
    apb(0, 12'h00C, 32'h0);
    chk({e, q}, {1'b0, 32'h0});
    wr_req <= 1'b0;
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    default_filter();
    deblock_filter();
    masked_edges();
    picture_and_map();
    tally_and_finish();
  end
endmodule
